// ---- hw/char_lcd_instruction_decoder.sv ----
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module char_lcd_instruction_decoder
	import lcd_pkg::*;
#(
	parameter int LONG_CYCLES       = lcd_pkg::EXEC_LONG_CYCLES,
	parameter int BLINK_HALF_CYCLES = lcd_pkg::BLINK_CYCLES
) (
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// axi4-lite write
	input  wire logic [lcd_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	// axi4-lite read
	input  wire logic [lcd_pkg::ADDR_W-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// display control
	output logic                           display_on,
	output logic                           cursor_on,
	output logic                           cursor_all_dots,
	output logic                           two_line,
	output logic                           font_tall,
	output lcd_pkg::duty_type              duty,
	output logic                           bus_width_select,
	output logic [5:0]                     shift_offset,
	output logic                           busy_flag
);
	import lcd_pkg::*;

	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic inc,
		input logic glyph, input logic two);
		logic [6:0] r;
		r = inc ? 7'(a + 7'h01) : 7'(a - 7'h01);
		if (glyph)
			r = {1'b0, r[5:0]};
		else if (two && inc && a == LINE1_LAST)
			r = LINE2_FIRST;
		else if (two && inc && a == LINE2_LAST)
			r = AC_HOME;
		else if (two && !inc && a == AC_HOME)
			r = LINE2_LAST;
		else if (two && !inc && a == LINE2_FIRST)
			r = LINE1_LAST;
		else if (!two && inc && a == ONE_LINE_LAST)
			r = AC_HOME;
		else if (!two && !inc && a == AC_HOME)
			r = ONE_LINE_LAST;
		return r;
	endfunction

	function automatic logic [5:0] shift_step(input logic [5:0] o, input logic left);
		logic [5:0] r;
		if (left)
			r = (o == SHIFT_LAST) ? 6'h00 : 6'(o + 6'h01);
		else
			r = (o == 6'h00) ? SHIFT_LAST : 6'(o - 6'h01);
		return r;
	endfunction

	function automatic op_type decode_op(input logic [7:0] b);
		op_type r;
		r = OP_NONE;
		if (b[7])
			r = OP_DISP_ADDR;
		else if (b[6])
			r = OP_GLYPH_ADDR;
		else if (b[5])
			r = OP_FUNC;
		else if (b[4])
			r = OP_SHIFT;
		else if (b[3])
			r = OP_ONOFF;
		else if (b[2])
			r = OP_ENTRY;
		else if (b[1])
			r = OP_HOME;
		else if (b[0])
			r = OP_CLEAR;
		return r;
	endfunction

	// bus state
	logic                  awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]            bresp_q, rresp_q;
	logic [31:0]           rdata_q;
	logic [ADDR_W-1:0]     awaddr_q, araddr_q;
	logic [7:0]            wbyte_q;
	rd_state_type          rd_q, rd_d;
	// controller state
	logic [6:0]            ac_q, ac_d;
	logic                  glyph_q, glyph_d, inc_q, inc_d, eshift_q, eshift_d;
	logic                  disp_q, disp_d, curs_q, curs_d, blink_q, blink_d;
	logic                  width_q, width_d, two_q, two_d, font_q, font_d;
	logic [5:0]            shift_q, shift_d;
	logic                  nib_q;
	logic [3:0]            nib_hold_q;
	logic [7:0]            rlatch_q;
	logic                  busy_q;
	logic [31:0]           busy_cnt_q;
	logic                  clr_q;
	logic [6:0]            clr_cnt_q;
	logic [31:0]           blink_cnt_q;
	logic                  blink_ph_q;
	duty_type              duty_q;
	logic [7:0]            mem_rdata;
	logic                  wstrb_q0;

	// write decode
	wire w_go      = !awready_q && !wready_q && !bvalid_q && rd_q == RD_IDLE;
	wire wa_cmd    = awaddr_q == OFS_CMD;
	wire wa_data   = awaddr_q == OFS_DATA;
	wire w_ok      = (wa_cmd || wa_data) && !busy_q && wstrb_q0;
	wire half      = !width_q && !nib_q;
	wire store_nib = w_go && w_ok && half;
	wire exec_w    = w_go && w_ok && !half;
	wire [7:0] wbyte_full = width_q ? wbyte_q : {nib_hold_q, wbyte_q[7:4]};
	wire exec_cmd  = exec_w && wa_cmd;
	wire exec_data = exec_w && wa_data;
	op_type op;
	assign op = exec_cmd ? decode_op(wbyte_full) : OP_NONE;
	wire long_op = op == OP_CLEAR || op == OP_HOME;

	// read decode
	wire ra_cmd    = araddr_q == OFS_CMD;
	wire ra_data   = araddr_q == OFS_DATA;
	wire ra_mode   = araddr_q == OFS_MODE;
	wire rd_lo     = !width_q && nib_q;
	wire rd_fetch  = rd_q == RD_DECODE && ra_data && !busy_q && !rd_lo;
	wire rd_step   = rd_q == RD_WAIT;
	wire rd_nib    = rd_q == RD_DECODE && (ra_cmd || (ra_data && !busy_q));
	wire [7:0] status_byte = {busy_q, ac_q};
	wire [7:0] mode_byte = {font_q, two_q, width_q, inc_q, eshift_q, disp_q, curs_q, blink_q};

	// ram port
	wire [7:0] ram_addr = glyph_q ? {GLYPH_BANK, ac_q[5:0]} : {1'b0, ac_q};
	wire [7:0] mem_addr = clr_q ? {1'b0, clr_cnt_q} : ram_addr;
	wire [7:0] mem_wdat = clr_q ? SPACE_CODE : wbyte_full;
	wire       mem_we   = clr_q || exec_data;

	char_ram #(
		.ADDR_BITS (8),
		.DATA_BITS (8)
	) u_ram (
		.aclk    (aclk),
		.we      (mem_we),
		.addr    (mem_addr),
		.wdata   (mem_wdat),
		.rdata_q (mem_rdata)
	);

	always_comb
	begin
		ac_d     = ac_q;
		glyph_d  = glyph_q;
		inc_d    = inc_q;
		eshift_d = eshift_q;
		disp_d   = disp_q;
		curs_d   = curs_q;
		blink_d  = blink_q;
		width_d  = width_q;
		two_d    = two_q;
		font_d   = font_q;
		shift_d  = shift_q;
		if (exec_data || rd_step)
			ac_d = step_addr(ac_q, inc_q, glyph_q, two_q);
		if (exec_data && eshift_q && !glyph_q)
			shift_d = shift_step(shift_q, inc_q);
		unique case (op)
			OP_CLEAR:
			begin
				ac_d    = AC_HOME;
				glyph_d = 1'b0;
				inc_d   = 1'b1;
				shift_d = 6'h00;
			end
			OP_HOME:
			begin
				ac_d    = AC_HOME;
				glyph_d = 1'b0;
				shift_d = 6'h00;
			end
			OP_ENTRY:
			begin
				inc_d    = wbyte_full[ENTRY_ID_BIT];
				eshift_d = wbyte_full[ENTRY_S_BIT];
			end
			OP_ONOFF:
			begin
				disp_d  = wbyte_full[ONOFF_D_BIT];
				curs_d  = wbyte_full[ONOFF_C_BIT];
				blink_d = wbyte_full[ONOFF_B_BIT];
			end
			OP_SHIFT:
			begin
				// a display shift leaves the counter alone
				if (wbyte_full[SHIFT_SC_BIT])
					shift_d = shift_step(shift_q, !wbyte_full[SHIFT_RL_BIT]);
				else
					ac_d = step_addr(ac_q, wbyte_full[SHIFT_RL_BIT], glyph_q, two_q);
			end
			OP_FUNC:
			begin
				width_d = wbyte_full[FUNC_DL_BIT];
				two_d   = wbyte_full[FUNC_N_BIT];
				font_d  = wbyte_full[FUNC_F_BIT];
			end
			OP_GLYPH_ADDR:
			begin
				ac_d    = {1'b0, wbyte_full[5:0]};
				glyph_d = 1'b1;
			end
			OP_DISP_ADDR:
			begin
				ac_d    = wbyte_full[6:0];
				glyph_d = 1'b0;
			end
			OP_NONE:
			begin
			end
		endcase
	end

	always_comb
	begin
		rd_d = rd_q;
		unique case (rd_q)
			RD_IDLE:   rd_d = (arvalid && arready_q) ? RD_DECODE : RD_IDLE;
			RD_DECODE: rd_d = rd_fetch ? RD_WAIT : RD_RESP;
			RD_WAIT:   rd_d = RD_RESP;
			RD_RESP:   rd_d = rready ? RD_IDLE : RD_RESP;
		endcase
	end

	// axi write channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= '0;
			wbyte_q   <= 8'h00;
		end
		else
		begin
			if (awvalid && awready_q)
			begin
				awaddr_q  <= awaddr;
				awready_q <= 1'b0;
			end
			if (wvalid && wready_q)
			begin
				wbyte_q  <= wdata[7:0];
				wready_q <= 1'b0;
			end
			if (w_go)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= w_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && bready)
			begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wstrb_q0 <= 1'b0;
		else if (wvalid && wready_q)
			wstrb_q0 <= wstrb[0];
	end

	// axi read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_q      <= RD_IDLE;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			araddr_q  <= '0;
		end
		else
		begin
			rd_q <= rd_d;
			if (arvalid && arready_q)
			begin
				araddr_q  <= araddr;
				arready_q <= 1'b0;
			end
			if (rd_q == RD_DECODE && !rd_fetch)
			begin
				rvalid_q <= 1'b1;
				rresp_q  <= (rd_nib || ra_mode) ? RESP_OKAY : RESP_SLVERR;
				if (ra_mode)
					rdata_q <= {24'h00_0000, mode_byte};
				else if (!rd_nib)
					rdata_q <= 32'h0000_0000;
				else if (rd_lo)
					rdata_q <= {24'h00_0000, rlatch_q[3:0], 4'h0};
				else if (width_q)
					rdata_q <= {24'h00_0000, status_byte};
				else
					rdata_q <= {24'h00_0000, status_byte[7:4], 4'h0};
			end
			if (rd_step)
			begin
				rvalid_q <= 1'b1;
				rresp_q  <= RESP_OKAY;
				rdata_q  <= width_q ? {24'h00_0000, mem_rdata}
					: {24'h00_0000, mem_rdata[7:4], 4'h0};
			end
			if (rvalid_q && rready)
			begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// controller registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ac_q <= AC_HOME;
			{glyph_q, eshift_q, disp_q, curs_q, blink_q, two_q, font_q} <= 7'h00;
			inc_q   <= RST_INC;
			width_q <= RST_WIDTH;
			shift_q <= 6'h00;
		end
		else
		begin
			ac_q     <= ac_d;
			glyph_q  <= glyph_d;
			inc_q    <= inc_d;
			eshift_q <= eshift_d;
			disp_q   <= disp_d;
			curs_q   <= curs_d;
			blink_q  <= blink_d;
			width_q  <= width_d;
			two_q    <= two_d;
			font_q   <= font_d;
			shift_q  <= shift_d;
		end
	end

	// nibble pairing, shared by reads and writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			nib_q      <= 1'b0;
			nib_hold_q <= 4'h0;
			rlatch_q   <= 8'h00;
		end
		else
		begin
			if (store_nib)
				nib_hold_q <= wbyte_q[7:4];
			if (rd_step)
				rlatch_q <= mem_rdata;
			else if (rd_q == RD_DECODE && ra_cmd && !rd_lo)
				rlatch_q <= status_byte;
			// entering nibble mode starts on the upper nibble
			if (width_d || width_q)
				nib_q <= 1'b0;
			else if (store_nib || exec_w || rd_step || (rd_nib && !ra_data) || (rd_nib && rd_lo))
				nib_q <= !nib_q;
		end
	end

	// busy timing and clear fill
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			busy_q     <= 1'b0;
			busy_cnt_q <= 32'h0000_0000;
			clr_q      <= 1'b0;
			clr_cnt_q  <= 7'h00;
		end
		else
		begin
			if (exec_w || rd_step)
			begin
				busy_q     <= 1'b1;
				busy_cnt_q <= long_op ? 32'(LONG_CYCLES) : 32'(EXEC_SHORT_CYCLES);
			end
			else if (busy_q)
			begin
				busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
				if (busy_cnt_q <= 32'h0000_0001)
					busy_q <= 1'b0;
			end
			if (op == OP_CLEAR)
			begin
				clr_q     <= 1'b1;
				clr_cnt_q <= 7'h00;
			end
			else if (clr_q)
			begin
				clr_cnt_q <= 7'(clr_cnt_q + 7'h01);
				if (clr_cnt_q == CLEAR_LAST)
					clr_q <= 1'b0;
			end
		end
	end

	// cursor blink and display outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			blink_cnt_q <= 32'h0000_0000;
			blink_ph_q  <= 1'b0;
			duty_q      <= DUTY_8;
		end
		else
		begin
			if (!blink_q)
			begin
				blink_cnt_q <= 32'h0000_0000;
				blink_ph_q  <= 1'b0;
			end
			else if (blink_cnt_q >= 32'(BLINK_HALF_CYCLES - 1))
			begin
				blink_cnt_q <= 32'h0000_0000;
				blink_ph_q  <= !blink_ph_q;
			end
			else
				blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
			duty_q <= two_d ? DUTY_16 : (font_d ? DUTY_11 : DUTY_8);
		end
	end

	assign awready          = awready_q;
	assign wready           = wready_q;
	assign bvalid           = bvalid_q;
	assign bresp            = bresp_q;
	assign arready          = arready_q;
	assign rvalid           = rvalid_q;
	assign rresp            = rresp_q;
	assign rdata            = rdata_q;
	assign display_on       = disp_q;
	assign cursor_on        = curs_q;
	assign cursor_all_dots  = blink_ph_q;
	assign two_line         = two_q;
	assign font_tall        = font_q;
	assign duty             = duty_q;
	assign bus_width_select = width_q;
	assign shift_offset     = shift_q;
	assign busy_flag        = busy_q;
endmodule

// ---- hw/lcd_pkg.sv ----
package lcd_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int EXEC_SHORT_NS = 18500;
	localparam int EXEC_LONG_NS  = 760000;
	localparam int BLINK_NS      = 185000000;

	function automatic int ns_to_cycles(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	localparam int EXEC_SHORT_CYCLES = ns_to_cycles(EXEC_SHORT_NS);
	localparam int EXEC_LONG_CYCLES  = ns_to_cycles(EXEC_LONG_NS);
	localparam int BLINK_CYCLES      = ns_to_cycles(BLINK_NS);

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CMD  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DATA = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h08;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [7:0] SPACE_CODE    = 8'h20;
	localparam logic [6:0] AC_HOME       = 7'h00;
	localparam logic [6:0] LINE1_LAST    = 7'h27;
	localparam logic [6:0] LINE2_FIRST   = 7'h40;
	localparam logic [6:0] LINE2_LAST    = 7'h67;
	localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
	localparam logic [6:0] CLEAR_LAST    = 7'h7F;
	localparam logic [5:0] SHIFT_LAST    = 6'h27;
	localparam logic [1:0] GLYPH_BANK    = 2'h2;

	localparam int ENTRY_ID_BIT = 1;
	localparam int ENTRY_S_BIT  = 0;
	localparam int ONOFF_D_BIT  = 2;
	localparam int ONOFF_C_BIT  = 1;
	localparam int ONOFF_B_BIT  = 0;
	localparam int SHIFT_SC_BIT = 3;
	localparam int SHIFT_RL_BIT = 2;
	localparam int FUNC_DL_BIT  = 4;
	localparam int FUNC_N_BIT   = 3;
	localparam int FUNC_F_BIT   = 2;

	localparam logic RST_INC   = 1'b1;
	localparam logic RST_WIDTH = 1'b1;

	typedef enum logic [1:0] {
		DUTY_8  = 2'h0,
		DUTY_11 = 2'h1,
		DUTY_16 = 2'h2
	} duty_type;

	typedef enum logic [1:0] {
		RD_IDLE   = 2'h0,
		RD_DECODE = 2'h1,
		RD_WAIT   = 2'h3,
		RD_RESP   = 2'h2
	} rd_state_type;

	typedef enum logic [3:0] {
		OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_ONOFF,
		OP_SHIFT, OP_FUNC, OP_GLYPH_ADDR, OP_DISP_ADDR
	} op_type;
endpackage

// ---- hw/char_ram.sv ----
`timescale 1ns/1ps
module char_ram #(
	parameter int ADDR_BITS = 8,
	parameter int DATA_BITS = 8
) (
	// clock
	input  wire logic                 aclk,
	// port
	input  wire logic                 we,
	input  wire logic [ADDR_BITS-1:0] addr,
	input  wire logic [DATA_BITS-1:0] wdata,
	output logic      [DATA_BITS-1:0] rdata_q
);
	logic [DATA_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];

	always_ff @(posedge aclk)
	begin
		if (we)
			mem[addr] <= wdata;
		rdata_q <= mem[addr];
	end
endmodule

// ---- test/lcd_props.sv ----
`timescale 1ns/1ps
module lcd_props
	import lcd_pkg::*;
#(
	parameter int LONG_CYCLES       = 50,
	parameter int BLINK_HALF_CYCLES = 8
) (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// bus
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready,
	// display
	input wire logic              two_line,
	input wire logic              font_tall,
	input wire lcd_pkg::duty_type duty,
	input wire logic              cursor_all_dots,
	input wire logic              busy_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int busy_len_q;
	int dots_len_q;
	always_ff @(posedge aclk)
	begin
		busy_len_q <= (aresetn && busy_flag) ? busy_len_q + 1 : 0;
		dots_len_q <= (aresetn && cursor_all_dots) ? dots_len_q + 1 : 0;
	end
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	property p_duty;
		duty == (two_line ? DUTY_16 : (font_tall ? DUTY_11 : DUTY_8));
	endproperty
	property p_busy_len;
		$fell(busy_flag) |->
			(busy_len_q >= EXEC_SHORT_CYCLES - 1 && busy_len_q <= EXEC_SHORT_CYCLES + 1) ||
			(busy_len_q >= LONG_CYCLES - 1 && busy_len_q <= LONG_CYCLES + 1);
	endproperty
	property p_b_lat;
		awvalid && awready && wvalid && wready |-> ##[1:12] bvalid;
	endproperty
	property p_r_lat;
		arvalid && arready |-> !rvalid ##1 !rvalid ##[1:2] rvalid;
	endproperty
	property p_aw_drop;
		awvalid && awready |=> !awready;
	endproperty
	property p_r_err;
		rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0;
	endproperty
	property p_blink;
		cursor_all_dots |-> dots_len_q < BLINK_HALF_CYCLES;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer not held");
	a_r_hold: assert property (p_r_hold) else $error("read answer not held");
	a_duty: assert property (p_duty) else $error("duty does not match flags");
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	a_b_lat: assert property (p_b_lat) else $error("write answer missing");
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	a_aw_drop: assert property (p_aw_drop) else $error("address slot still open");
	a_r_err: assert property (p_r_err) else $error("refused read carries data");
	a_blink: assert property (p_blink) else $error("blink phase too long");
	c_refused: cover property (bvalid && bresp == RESP_SLVERR);
	c_busy: cover property ($rose(busy_flag));
	c_blink: cover property ($rose(cursor_all_dots));
endmodule

bind char_lcd_instruction_decoder lcd_props #(
	.LONG_CYCLES      (LONG_CYCLES),
	.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) u_props (
	.aclk            (aclk),
	.aresetn         (aresetn),
	.awvalid         (awvalid),
	.awready         (awready),
	.wvalid          (wvalid),
	.wready          (wready),
	.bresp           (bresp),
	.bvalid          (bvalid),
	.bready          (bready),
	.arvalid         (arvalid),
	.arready         (arready),
	.rdata           (rdata),
	.rresp           (rresp),
	.rvalid          (rvalid),
	.rready          (rready),
	.two_line        (two_line),
	.font_tall       (font_tall),
	.duty            (duty),
	.cursor_all_dots (cursor_all_dots),
	.busy_flag       (busy_flag)
);

// ---- test/axi_host.sv ----
`timescale 1ns/1ps
module axi_host (
	// clock
	input  wire logic                        aclk,
	// write
	output logic [lcd_pkg::ADDR_W-1:0] awaddr  = '0,
	output logic                       awvalid = 1'b0,
	input  wire logic                  awready,
	output logic [31:0]                wdata   = '0,
	output logic [3:0]                 wstrb   = '0,
	output logic                       wvalid  = 1'b0,
	input  wire logic                  wready,
	input  wire logic [1:0]            bresp,
	input  wire logic                  bvalid,
	output logic                       bready  = 1'b0,
	// read
	output logic [lcd_pkg::ADDR_W-1:0] araddr  = '0,
	output logic                       arvalid = 1'b0,
	input  wire logic                  arready,
	input  wire logic [31:0]           rdata,
	input  wire logic [1:0]            rresp,
	input  wire logic                  rvalid,
	output logic                       rready  = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				r = bresp;
		end
		while (bvalid !== 1'b1 && n < 200);
		bready <= 1'b0;
		if (bvalid !== 1'b1)
			tb.hang();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
			d = rdata;
			r = rresp;
		end
		while (rvalid !== 1'b1 && n < 200);
		rready <= 1'b0;
		if (rvalid !== 1'b1)
			tb.hang();
	endtask
	// polls status until the ready state before the next instruction
	task automatic idle();
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		d = 32'h80;
		for (n = 0; n < 3000 && d[7] !== 1'b0; n++)
			rd(lcd_pkg::OFS_CMD, d, r);
		if (d[7] !== 1'b0)
			tb.hang();
	endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
	import lcd_pkg::*;
	localparam int LONG  = 200;
	localparam int BLINK = 8;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, d;
	logic [3:0]        wstrb, hi;
	logic [1:0]        bresp, rresp, r;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic              display_on, cursor_on, cursor_all_dots, two_line, font_tall;
	logic              bus_width_select, busy_flag;
	logic [5:0]        shift_offset;
	duty_type          duty;
	int                err_total = 0;
	int                check_count = 0;
	logic [7:0]        fs [3] = '{8'h30, 8'h34, 8'h3C};
	duty_type          dt [3] = '{DUTY_8, DUTY_11, DUTY_16};
	logic [7:0]        sc [4] = '{8'h10, 8'h14, 8'h18, 8'h1C};
	logic [7:0]        sa [4] = '{8'h26, 8'h27, 8'h27, 8'h27};
	logic [5:0]        so [4] = '{6'h0, 6'h0, 6'h1, 6'h0};
	logic [7:0]        ea [3] = '{8'h0C, OFS_MODE, OFS_CMD};
	logic [3:0]        es [3] = '{4'h1, 4'h1, 4'h0};

	always #4 aclk = ~aclk;

	char_lcd_instruction_decoder #(
		.LONG_CYCLES      (LONG),
		.BLINK_HALF_CYCLES(BLINK)
	) u_dut (.*);
	axi_host u_host (.*);

	task automatic chk(input logic [9:0] s, input logic [9:0] e);
		check_count++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] %0t: got %h, want %h", $time, s, e);
		end
	endtask
	task automatic results();
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic hang();
		err_total++;
		results();
	endtask
	task automatic put(input logic [7:0] a, input logic [7:0] b);
		u_host.wr(a, {24'h0, b}, 4'h1, r);
		chk({r, 8'h0}, {RESP_OKAY, 8'h0});
		u_host.idle();
	endtask
	task automatic get(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, d, r);
		chk({r, d[7:0]}, {RESP_OKAY, e});
		u_host.idle();
	endtask
	// nibble mode: status polling would split pairs, so wait out the short busy
	task automatic nib(input logic [7:0] b);
		u_host.wr(OFS_CMD, {24'h0, b[7:4], 4'h0}, 4'h1, r);
		u_host.wr(OFS_CMD, {24'h0, b[3:0], 4'h0}, 4'h1, r);
		chk({r, 8'h0}, {RESP_OKAY, 8'h0});
		repeat (EXEC_SHORT_CYCLES + 8) @(posedge aclk);
	endtask

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		get(OFS_MODE, 8'h30);
		put(OFS_CMD, 8'h01);
		get(OFS_CMD, 8'h00);
		put(OFS_DATA, 8'h41);
		u_host.wr(OFS_DATA, 32'h42, 4'h1, r);
		u_host.rd(OFS_CMD, d, r);
		chk({r, d[7:0]}, {RESP_OKAY, 8'h82});
		u_host.wr(OFS_DATA, 32'h43, 4'h1, r);
		chk({r, 8'h0}, {RESP_SLVERR, 8'h0});
		u_host.rd(OFS_DATA, d, r);
		chk({r, d[7:0]}, {RESP_SLVERR, 8'h00});
		u_host.idle();
		put(OFS_CMD, 8'h80);
		get(OFS_DATA, 8'h41);
		get(OFS_DATA, 8'h42);
		get(OFS_DATA, SPACE_CODE);
		foreach (fs[i])
		begin
			put(OFS_CMD, fs[i]);
			chk({7'h0, two_line, duty}, {7'h0, i == 2, dt[i]});
		end
		put(OFS_CMD, 8'hA7);
		put(OFS_DATA, 8'h44);
		get(OFS_CMD, 8'h40);
		put(OFS_CMD, 8'h04);
		put(OFS_DATA, 8'h45);
		get(OFS_CMD, 8'h27);
		foreach (sc[i])
		begin
			put(OFS_CMD, sc[i]);
			get(OFS_CMD, sa[i]);
			chk({4'h0, shift_offset}, {4'h0, so[i]});
		end
		put(OFS_CMD, 8'h07);
		put(OFS_DATA, 8'h46);
		get(OFS_DATA, 8'h45);
		chk({4'h0, shift_offset}, 10'h1);
		put(OFS_CMD, 8'h02);
		chk({4'h0, shift_offset}, 10'h0);
		get(OFS_DATA, 8'h41);
		put(OFS_CMD, 8'h45);
		get(OFS_CMD, 8'h05);
		put(OFS_DATA, 8'h1F);
		chk({4'h0, shift_offset}, 10'h0);
		put(OFS_CMD, 8'h45);
		get(OFS_DATA, 8'h1F);
		put(OFS_CMD, 8'h0F);
		hi = {3'h0, cursor_all_dots};
		repeat (BLINK) @(posedge aclk);
		chk({7'h0, display_on, cursor_on, cursor_all_dots ^ hi[0]}, 10'h7);
		put(OFS_CMD, 8'h0C);
		chk({8'h0, cursor_on, cursor_all_dots}, 10'h0);
		get(OFS_MODE, 8'hFC);
		put(OFS_CMD, 8'h08);
		chk({9'h0, display_on}, 10'h0);
		put(OFS_CMD, 8'h80);
		get(OFS_DATA, 8'h41);
		foreach (ea[i])
		begin
			u_host.wr(ea[i], 32'h1, es[i], r);
			chk({r, 8'h0}, {RESP_SLVERR, 8'h0});
		end
		get(OFS_CMD, 8'h01);
		u_host.wr(OFS_CMD, 32'h2C, 4'h1, r);
		repeat (EXEC_SHORT_CYCLES + 8) @(posedge aclk);
		chk({9'h0, bus_width_select}, 10'h0);
		nib(8'h83);
		u_host.rd(OFS_CMD, d, r);
		hi = d[7:4];
		u_host.rd(OFS_CMD, d, r);
		chk({r, hi, d[7:4]}, {RESP_OKAY, 8'h03});
		nib(8'h38);
		chk({9'h0, bus_width_select}, 10'h1);
		results();
	end
endmodule
